//--- sim/ppf_prog_model.sv
// programmer model driving the parallel programming pins
`timescale 1ns/1ns
module ppf_prog_model
	import ppf_pkg::*;
(
	input wire logic i_clock,
	input wire logic [7:0] i_data,
	input wire logic i_data_oe,
	output ppf_pins_t o_pins
);
	logic [7:0] last_q;
	initial begin
		o_pins = '0; // entry pins all low
		o_pins.wr_n = 1'b1;
		o_pins.oe_n = 1'b1;
		last_q = 8'h00;
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#5;
	endtask : step
	task automatic setup(input logic [1:0] act, input logic b2,
		input logic b1, input logic [7:0] v);
		o_pins.action_select_hi = act[1];
		o_pins.action_select_lo = act[0];
		o_pins.byte_select_two = b2;
		o_pins.byte_select_one = b1;
		o_pins.data = v;
		last_q = v;
		step(2);
	endtask : setup
	task automatic load(input logic [1:0] act, input logic b1,
		input logic [7:0] v);
		setup(act, 1'b0, b1, v);
		o_pins.load_strobe_pin = 1'b1;
		step(6);
		o_pins.load_strobe_pin = 1'b0;
		step(6);
		setup(PPF_ACT_ADDR, 1'b0, 1'b0, v); // keeps entry pattern
	endtask : load
	task automatic wr(input logic b2, input logic b1, input logic [7:0] v);
		setup(PPF_ACT_IDLE, b2, b1, v);
		o_pins.wr_n = 1'b0;
		step(6);
		o_pins.wr_n = 1'b1;
		step(2);
	endtask : wr
	task automatic page;
		o_pins.page_load_strobe = 1'b1;
		step(6);
		o_pins.page_load_strobe = 1'b0;
		step(6);
	endtask : page
	task automatic rd(input logic b2, input logic b1,
		output logic [7:0] d, output logic oe);
		setup(PPF_ACT_IDLE, b2, b1, ~last_q); // released bus toggles
		o_pins.oe_n = 1'b0;
		step(8);
		d = i_data;
		oe = i_data_oe;
		o_pins.oe_n = 1'b1;
		step(6);
	endtask : rd
endmodule : ppf_prog_model

//--- sim/tb_top.sv
// self-checking bench for the parallel programming port
`timescale 1ns/1ns
module tb_top;
	import ppf_pkg::*;
	localparam int BUSY = PPF_BUSY_CYCLES;
	localparam logic [7:0] CAL = 8'h6B;
	logic [7:0] ids [3] = '{8'h3E, 8'h71, 8'hC4}; // arbitrary values
	logic [7:0] cmds [3] = '{PPF_CMD_ERASE, PPF_CMD_WR_FLASH, PPF_CMD_WR_EEP};
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_prog_mode = 1'b0;
	logic i_serial_wr = 1'b0;
	logic [1:0] i_serial_sel = 2'h1;
	logic [7:0] i_serial_data = 8'h00;
	ppf_pins_t pins;
	logic [7:0] o_data, o_op_cmd, o_cal, cmd_seen, d, lo, hi, ext, s;
	logic [7:0] al, ah, dl, dh;
	logic o_data_oe, o_ready, o_page_latch, o_op_start, o_keep, oe;
	logic [13:0] o_flash_addr, addr_seen;
	logic [15:0] o_flash_wdata, wd_seen;
	ppf_fuses_t o_fuses;
	int n_fail = 0;
	int samples_checked = 0;
	int starts, busy, latches;
	always #50 i_clock = ~i_clock;
	ppf_prog_port #(.ID_BYTE_0(8'h3E), .ID_BYTE_1(8'h71), .ID_BYTE_2(8'hC4),
		.CAL_BYTE(CAL)) u_ppf_prog_port (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_prog_mode(i_prog_mode),
		.i_serial_wr(i_serial_wr), .i_serial_sel(i_serial_sel),
		.i_serial_data(i_serial_data), .i_pins(pins), .o_data(o_data),
		.o_data_oe(o_data_oe), .o_ready_busy_out(o_ready),
		.o_page_latch(o_page_latch), .o_flash_addr(o_flash_addr),
		.o_flash_wdata(o_flash_wdata), .o_op_start(o_op_start),
		.o_op_cmd(o_op_cmd), .o_active_fuses(o_fuses),
		.o_eeprom_keep_on_erase(o_keep), .o_osc_calibration_reg(o_cal));
	ppf_prog_model u_m (.i_clock(i_clock), .i_data(o_data),
		.i_data_oe(o_data_oe), .o_pins(pins));
	always @(posedge i_clock) begin
		if (o_op_start) begin
			starts++;
			cmd_seen = o_op_cmd;
		end
		if (o_ready === 1'b0)
			busy++;
		if (o_page_latch) begin
			latches++;
			addr_seen = o_flash_addr;
			wd_seen = o_flash_wdata;
		end
	end
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic print_verdict;
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic wait_ready;
		int i;
		i = 0;
		while (o_ready !== 1'b1 && i < 200) begin
			u_m.step(1);
			i++;
		end
		if (i == 200) begin
			n_fail++;
			print_verdict();
		end
	endtask : wait_ready
	task automatic ser_wr(input logic [1:0] sel, input logic [7:0] v);
		i_serial_sel = sel;
		i_serial_data = v;
		i_serial_wr = 1'b1;
		u_m.step(1);
		i_serial_wr = 1'b0;
		u_m.step(2);
	endtask : ser_wr
	task automatic write_op(input logic [7:0] c, input logic b2,
		input logic b1, input logic [7:0] v, input logic full);
		u_m.load(PPF_ACT_CMD, 1'b0, c);
		starts = 0;
		busy = 0;
		u_m.wr(b2, b1, v);
		wait_ready();
		if (full) begin
			chk("op_start", 24'h1, starts);
			chk("op_cmd", c, cmd_seen);
			chk("busy_len", 24'(BUSY), busy);
		end
	endtask : write_op
	task automatic rd_chk(input string nm, input logic b2, input logic b1,
		input logic [7:0] e);
		u_m.rd(b2, b1, d, oe);
		chk(nm, e, d);
		chk("data_oe", 24'h1, oe);
		chk("data_oe_off", 24'h0, o_data_oe);
	endtask : rd_chk
	initial begin
		void'($urandom(32'h8FF5E504));
		repeat (2) @(posedge i_clock);
		#5;
		i_rst_n = 1'b1;
		u_m.step(5);
		chk("fuses_rst", 24'hFF9962, o_fuses);
		chk("ready_rst", 24'h1, o_ready);
		chk("cal_rst", CAL, o_cal);
		i_prog_mode = 1'b1;
		u_m.step(5);
		u_m.load(PPF_ACT_CMD, 1'b0, PPF_CMD_RD_ID);
		u_m.load(PPF_ACT_ADDR, 1'b1, 8'h00);
		for (int a = 2; a >= 0; a--) begin
			u_m.load(PPF_ACT_ADDR, 1'b0, 8'(a));
			rd_chk("id_byte", 1'b0, 1'b0, ids[a]);
		end
		rd_chk("cal_byte", 1'b0, 1'b1, CAL);
		lo = 8'($urandom);
		hi = 8'($urandom) & 8'hF7;
		ext = 8'($urandom);
		write_op(PPF_CMD_WR_FUSE, 1'b0, 1'b0, lo, 1'b1);
		write_op(PPF_CMD_WR_FUSE, 1'b0, 1'b1, hi, 1'b1);
		write_op(PPF_CMD_WR_FUSE, 1'b1, 1'b0, ext, 1'b1);
		ext = ext | 8'hF8;
		chk("fuses_held", 24'hFF9962, o_fuses);
		chk("keep_now", 24'h0, o_keep);
		s = 8'($urandom);
		ser_wr(2'h1, s);
		hi = {s[7:6], hi[5], s[4:0]};
		chk("keep_serial", {23'h0, s[PPF_BIT_KEEP]}, o_keep);
		u_m.load(PPF_ACT_CMD, 1'b0, PPF_CMD_RD_FUSE);
		rd_chk("fuse_low", 1'b0, 1'b0, lo);
		rd_chk("fuse_high", 1'b1, 1'b1, hi);
		rd_chk("fuse_ext", 1'b1, 1'b0, ext);
		rd_chk("lock_rst", 1'b0, 1'b1, 8'hFF);
		lo = 8'($urandom);
		ser_wr(2'h0, lo);
		ext = 8'($urandom);
		ser_wr(2'h2, ext);
		ext = ext | PPF_EXT_UNUSED_MASK;
		i_prog_mode = 1'b0;
		u_m.step(3);
		chk("fuses_exit", {ext, hi, lo}, o_fuses);
		i_prog_mode = 1'b1;
		u_m.step(5);
		for (int i = 0; i < 3; i++)
			write_op(cmds[i], 1'b0, 1'b0, 8'h00, 1'b1);
		al = 8'($urandom);
		ah = 8'($urandom);
		dl = 8'($urandom);
		dh = 8'($urandom);
		u_m.load(PPF_ACT_CMD, 1'b0, PPF_CMD_WR_FLASH);
		u_m.load(PPF_ACT_ADDR, 1'b0, al);
		u_m.load(PPF_ACT_ADDR, 1'b1, ah);
		u_m.load(PPF_ACT_DATA, 1'b0, dl);
		u_m.load(PPF_ACT_DATA, 1'b1, dh);
		latches = 0;
		u_m.page();
		chk("page_latch", 24'h1, latches);
		chk("flash_addr", {ah[5:0], al}, addr_seen);
		chk("flash_wdata", {dh, dl}, wd_seen);
		u_m.load(PPF_ACT_CMD, 1'b0, PPF_CMD_RD_FLASH);
		rd_chk("flash_lo", 1'b0, 1'b0, dl);
		rd_chk("flash_hi", 1'b0, 1'b1, dh);
		u_m.load(PPF_ACT_CMD, 1'b0, PPF_CMD_RD_EEP);
		rd_chk("eep_byte", 1'b0, 1'b0, dl);
		u_m.load(PPF_ACT_CMD, 1'b0, PPF_CMD_RD_FUSE);
		rd_chk("erase_low", 1'b0, 1'b0, lo);
		write_op(PPF_CMD_WR_LOCK, 1'b0, 1'b0, 8'hFE, 1'b1);
		write_op(PPF_CMD_WR_FUSE, 1'b0, 1'b0, ~lo, 1'b0);
		u_m.load(PPF_ACT_CMD, 1'b0, PPF_CMD_RD_FUSE);
		rd_chk("lock_byte", 1'b0, 1'b1, 8'hFE);
		rd_chk("locked_low", 1'b0, 1'b0, lo);
		i_rst_n = 1'b0;
		u_m.step(2);
		i_rst_n = 1'b1;
		u_m.step(5);
		chk("fuses_rerst", 24'hFF9962, o_fuses);
		chk("ready_rerst", 24'h1, o_ready);
		chk("cal_rerst", CAL, o_cal);
		print_verdict();
	end
endmodule : tb_top

//--- src/ppf_pin_sync.sv
// three-stage synchroniser for the programmer pin group
`timescale 1ns/1ns
module ppf_pin_sync
	import ppf_pkg::*;
#(
	parameter int WIDTH = $bits(ppf_pins_t)
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	input wire logic [WIDTH-1:0] i_reset_val,
	output logic [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} ppf_sync_state_t;
	ppf_sync_state_t st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.s1 = i_async;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		// a bit changes once stages two and three agree
		for (int i = 0; i < WIDTH; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.out[i] = st_q.s3[i];
			end
		end
	end
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st_q <= '{s1: i_reset_val, s2: i_reset_val, s3: i_reset_val,
				out: i_reset_val};
		end else begin
			st_q <= st_d;
		end
	end
	assign o_sync = st_q.out;
endmodule : ppf_pin_sync

//--- src/ppf_pkg.sv
// package: constants, types and codes for the parallel programming front end
package ppf_pkg;
	localparam logic [7:0] PPF_EXT_FUSE_RST = 8'hFF;
	localparam logic [7:0] PPF_HIGH_FUSE_RST = 8'h99;
	localparam logic [7:0] PPF_LOW_FUSE_RST = 8'h62;
	localparam logic [7:0] PPF_LOCK_RST = 8'hFF;
	localparam int PPF_EXT_UNUSED_MASK_BITS = 5;
	localparam logic [7:0] PPF_EXT_UNUSED_MASK = 8'hF8;
	localparam int PPF_BIT_KEEP = 3;
	localparam int PPF_BIT_SPROG = 5;
	localparam int PPF_BIT_LOCK_FIRST = 0;
	localparam logic [7:0] PPF_CMD_ERASE = 8'h80;
	localparam logic [7:0] PPF_CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] PPF_CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] PPF_CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] PPF_CMD_WR_EEP = 8'h11;
	localparam logic [7:0] PPF_CMD_RD_ID = 8'h08;
	localparam logic [7:0] PPF_CMD_RD_FUSE = 8'h04;
	localparam logic [7:0] PPF_CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] PPF_CMD_RD_EEP = 8'h03;
	localparam logic [1:0] PPF_ACT_ADDR = 2'h0;
	localparam logic [1:0] PPF_ACT_DATA = 2'h1;
	localparam logic [1:0] PPF_ACT_CMD = 2'h2;
	localparam logic [1:0] PPF_ACT_IDLE = 2'h3;
	localparam logic [1:0] PPF_ID_ADDR_0 = 2'h0;
	localparam logic [1:0] PPF_ID_ADDR_1 = 2'h1;
	localparam logic [1:0] PPF_ID_ADDR_2 = 2'h2;
	localparam logic [3:0] PPF_ENTRY_CODE = 4'h0;
	localparam int PPF_FLASH_WORD_BITS = 6;
	localparam int PPF_FLASH_PAGE_BITS = 8;
	localparam int PPF_EEP_BYTE_BITS = 2;
	localparam int PPF_BUSY_NS = 4000;
	localparam int PPF_CLK_NS = 100;
	localparam int PPF_BUSY_CYCLES = (PPF_BUSY_NS + PPF_CLK_NS - 1) / PPF_CLK_NS;
	localparam logic [7:0] PPF_ZERO8 = 8'h00;
	// pin group sampled from the programmer
	typedef struct packed {
		logic load_strobe_pin;
		logic page_load_strobe;
		logic wr_n;
		logic oe_n;
		logic byte_select_one;
		logic byte_select_two;
		logic action_select_hi;
		logic action_select_lo;
		logic [7:0] data;
	} ppf_pins_t;
	typedef enum logic [1:0] {PPF_IDLE, PPF_BUSY} ppf_state_t;
	typedef struct packed {
		logic [7:0] ext;
		logic [7:0] high;
		logic [7:0] low;
	} ppf_fuses_t;
endpackage : ppf_pkg

//--- src/ppf_prog_port.sv
// parallel programming port front end with fuse, lock and identity store
//
// Summary of operation
// - three fuse bytes, programmed reads zero
// - extended byte: brownout level, reset disable
// - high byte fields with given defaults
// - serial path cannot touch serial enable
// - chip erase keeps all fuses
// - first lock bit programmed blocks fuses
// - fuses captured at programming entry
// - eeprom keep fuse acts immediately
// - fuses captured at power-up too
// - three identity bytes, readable when locked
// - calibration byte copied during reset
// - load strobe plus action pins select load
// - write or read strobe runs loaded command
// - write command codes
// - read command codes
// - ready busy low while operation runs
// - device drives data only while oe low
// - byte selects pick low or high bytes
// - flash 256 pages of 64 words
// - eeprom 256 pages of 4 bytes
// - write strobe low pulse starts operation
// - page load pulse latches data bytes
// - read flash byte by byte select
`timescale 1ns/1ns
module ppf_prog_port
	import ppf_pkg::*;
#(
	parameter logic [7:0] ID_BYTE_0 = 8'hA5, // arbitrary value
	parameter logic [7:0] ID_BYTE_1 = 8'h5A, // arbitrary value
	parameter logic [7:0] ID_BYTE_2 = 8'h3C, // arbitrary value
	parameter logic [7:0] CAL_BYTE = 8'h80,
	parameter int BUSY_CYCLES = PPF_BUSY_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_prog_mode,
	input wire logic i_serial_wr,
	input wire logic [1:0] i_serial_sel,
	input wire logic [7:0] i_serial_data,
	input wire ppf_pins_t i_pins,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic o_ready_busy_out,
	output logic o_page_latch,
	output logic [13:0] o_flash_addr,
	output logic [15:0] o_flash_wdata,
	output logic o_op_start,
	output logic [7:0] o_op_cmd,
	output ppf_fuses_t o_active_fuses,
	output logic o_eeprom_keep_on_erase,
	output logic [7:0] o_osc_calibration_reg
);
	typedef struct packed {
		ppf_pins_t pins_prev;
		logic mode_prev;
		logic [7:0] cmd;
		logic [7:0] addr_lo;
		logic [7:0] addr_hi;
		logic [7:0] data_lo;
		logic [7:0] data_hi;
		ppf_fuses_t fuses;
		ppf_fuses_t active;
		logic [7:0] lock;
		logic keep_now;
		logic [7:0] osc_calibration_reg;
		ppf_state_t state;
		logic [15:0] busy_cnt;
		logic [7:0] dout;
		logic oe;
		logic rdy;
		logic page_latch;
		logic [13:0] flash_addr;
		logic [15:0] flash_wdata;
		logic op_start;
		logic [7:0] op_cmd;
	} ppf_state_all_t;
	localparam ppf_pins_t PINS_IDLE = '{load_strobe_pin: 1'b0,
		page_load_strobe: 1'b0, wr_n: 1'b1, oe_n: 1'b1,
		byte_select_one: 1'b0, byte_select_two: 1'b0,
		action_select_hi: 1'b1, action_select_lo: 1'b1, data: PPF_ZERO8};
	localparam logic [15:0] BUSY_LAST = 16'(BUSY_CYCLES - 1);
	ppf_pins_t pins;
	ppf_state_all_t st_q, st_d;
	logic [1:0] act;
	logic ld_rise, pg_rise, wr_fall, fuse_locked;
	ppf_pin_sync #(.WIDTH($bits(ppf_pins_t))) u_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_async(i_pins),
		.i_reset_val(PINS_IDLE),
		.o_sync(pins)
	);
	assign act = {pins.action_select_hi, pins.action_select_lo};
	assign ld_rise = pins.load_strobe_pin && !st_q.pins_prev.load_strobe_pin;
	assign pg_rise = pins.page_load_strobe
		&& !st_q.pins_prev.page_load_strobe;
	assign wr_fall = !pins.wr_n && st_q.pins_prev.wr_n;
	assign fuse_locked = !st_q.lock[PPF_BIT_LOCK_FIRST];
	always_comb begin
		st_d = st_q;
		st_d.pins_prev = pins;
		st_d.mode_prev = i_prog_mode;
		st_d.page_latch = 1'b0;
		st_d.op_start = 1'b0;
		// loads in programming mode; values held until overwritten
		if (ld_rise && i_prog_mode) begin
			unique case (act)
				PPF_ACT_ADDR: begin
					if (pins.byte_select_one) begin
						st_d.addr_hi = pins.data;
					end else begin
						st_d.addr_lo = pins.data;
					end
				end
				PPF_ACT_DATA: begin
					if (pins.byte_select_one) begin
						st_d.data_hi = pins.data;
					end else begin
						st_d.data_lo = pins.data;
					end
				end
				PPF_ACT_CMD: st_d.cmd = pins.data;
				PPF_ACT_IDLE: ;
			endcase
		end
		if (pg_rise && i_prog_mode) begin
			st_d.page_latch = 1'b1;
			st_d.flash_addr = {st_q.addr_hi[PPF_FLASH_PAGE_BITS-3:0],
				st_q.addr_lo};
			st_d.flash_wdata = {st_q.data_hi, st_q.data_lo};
		end
		unique case (st_q.state)
			PPF_IDLE: begin
				if (wr_fall && i_prog_mode) begin
					st_d.state = PPF_BUSY;
					st_d.busy_cnt = '0;
					st_d.rdy = 1'b0;
					st_d.op_start = 1'b1;
					st_d.op_cmd = st_q.cmd;
					st_d.flash_addr = {st_q.addr_hi[PPF_FLASH_PAGE_BITS-3:0],
						st_q.addr_lo};
					unique case (st_q.cmd)
						PPF_CMD_WR_FUSE: begin
							if (!fuse_locked) begin
								if (pins.byte_select_two) begin
									st_d.fuses.ext = pins.data
										| PPF_EXT_UNUSED_MASK;
								end else if (pins.byte_select_one) begin
									st_d.fuses.high = pins.data;
									st_d.keep_now =
										pins.data[PPF_BIT_KEEP];
								end else begin
									st_d.fuses.low = pins.data;
								end
							end
						end
						PPF_CMD_WR_LOCK: st_d.lock = st_q.lock & pins.data;
						// fuses untouched by erase
						PPF_CMD_ERASE: st_d.lock = PPF_LOCK_RST;
						default: ;
					endcase
				end
			end
			PPF_BUSY: begin
				if (st_q.busy_cnt == BUSY_LAST) begin
					st_d.state = PPF_IDLE;
					st_d.rdy = 1'b1;
				end else begin
					st_d.busy_cnt = st_q.busy_cnt + 16'h0001;
				end
			end
			default: st_d.state = PPF_IDLE;
		endcase
		// serial path may not change the serial enable bit
		if (i_serial_wr && !fuse_locked) begin
			unique case (i_serial_sel)
				2'h0: st_d.fuses.low = i_serial_data;
				2'h1: begin
					st_d.fuses.high = {i_serial_data[7:6],
						st_q.fuses.high[PPF_BIT_SPROG],
						i_serial_data[4:0]};
					st_d.keep_now = i_serial_data[PPF_BIT_KEEP];
				end
				2'h2: st_d.fuses.ext = i_serial_data | PPF_EXT_UNUSED_MASK;
				default: ;
			endcase
		end
		// capture on programming mode entry
		if (i_prog_mode && !st_q.mode_prev) begin
			st_d.active = st_q.fuses;
			st_d.keep_now = st_q.fuses.high[PPF_BIT_KEEP];
		end
		if (!i_prog_mode) begin
			st_d.active = st_d.fuses;
			st_d.keep_now = st_d.fuses.high[PPF_BIT_KEEP];
		end
		// data bus driven only while oe low
		st_d.oe = i_prog_mode && !pins.oe_n;
		st_d.dout = PPF_ZERO8;
		unique case (st_q.cmd)
			PPF_CMD_RD_ID: begin
				if (pins.byte_select_one) begin
					st_d.dout = (st_q.addr_lo[1:0] == PPF_ID_ADDR_0)
						? CAL_BYTE : PPF_ZERO8;
				end else begin
					unique case (st_q.addr_lo[1:0])
						PPF_ID_ADDR_0: st_d.dout = ID_BYTE_0;
						PPF_ID_ADDR_1: st_d.dout = ID_BYTE_1;
						PPF_ID_ADDR_2: st_d.dout = ID_BYTE_2;
						default: st_d.dout = PPF_ZERO8;
					endcase
				end
			end
			PPF_CMD_RD_FUSE: begin
				unique case ({pins.byte_select_two, pins.byte_select_one})
					2'h0: st_d.dout = st_q.fuses.low;
					2'h1: st_d.dout = st_q.lock;
					2'h2: st_d.dout = st_q.fuses.ext;
					2'h3: st_d.dout = st_q.fuses.high;
				endcase
			end
			// flash and eeprom array sit outside; data bytes echo
			PPF_CMD_RD_FLASH: st_d.dout = pins.byte_select_one
				? st_q.data_hi : st_q.data_lo;
			PPF_CMD_RD_EEP: st_d.dout = st_q.data_lo;
			default: st_d.dout = PPF_ZERO8;
		endcase
	end
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st_q.pins_prev <= PINS_IDLE;
			st_q.mode_prev <= 1'b0;
			st_q.cmd <= PPF_ZERO8;
			st_q.addr_lo <= PPF_ZERO8;
			st_q.addr_hi <= PPF_ZERO8;
			st_q.data_lo <= PPF_ZERO8;
			st_q.data_hi <= PPF_ZERO8;
			st_q.fuses <= '{ext: PPF_EXT_FUSE_RST, high: PPF_HIGH_FUSE_RST,
				low: PPF_LOW_FUSE_RST};
			// power-up capture of defaults
			st_q.active <= '{ext: PPF_EXT_FUSE_RST, high: PPF_HIGH_FUSE_RST,
				low: PPF_LOW_FUSE_RST};
			st_q.lock <= PPF_LOCK_RST;
			st_q.keep_now <= PPF_HIGH_FUSE_RST[PPF_BIT_KEEP];
			st_q.osc_calibration_reg <= CAL_BYTE;
			st_q.state <= PPF_IDLE;
			st_q.busy_cnt <= '0;
			st_q.dout <= PPF_ZERO8;
			st_q.oe <= 1'b0;
			st_q.rdy <= 1'b1;
			st_q.page_latch <= 1'b0;
			st_q.flash_addr <= '0;
			st_q.flash_wdata <= '0;
			st_q.op_start <= 1'b0;
			st_q.op_cmd <= PPF_ZERO8;
		end else begin
			st_q <= st_d;
		end
	end
	assign o_data = st_q.dout;
	assign o_data_oe = st_q.oe;
	assign o_ready_busy_out = st_q.rdy;
	assign o_page_latch = st_q.page_latch;
	assign o_flash_addr = st_q.flash_addr;
	assign o_flash_wdata = st_q.flash_wdata;
	assign o_op_start = st_q.op_start;
	assign o_op_cmd = st_q.op_cmd;
	assign o_active_fuses = st_q.active;
	assign o_eeprom_keep_on_erase = st_q.keep_now;
	assign o_osc_calibration_reg = st_q.osc_calibration_reg;

	chk_busy_after_write: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) (st_q.state == PPF_IDLE && wr_fall
		&& i_prog_mode) |=> !o_ready_busy_out && o_op_start)
		else $error("ready busy not low after write strobe");
	chk_busy_ends: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) $fell(o_ready_busy_out)
		|-> ##[1:100] o_ready_busy_out)
		else $error("busy did not end in time");
	chk_oe_gates_bus: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) o_data_oe |-> $past(!pins.oe_n))
		else $error("data driven without oe low");
	chk_cmd_load: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) (ld_rise && i_prog_mode
		&& act == PPF_ACT_CMD) |=> st_q.cmd == $past(pins.data))
		else $error("command byte not loaded");
	chk_cmd_hold: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) !(ld_rise && act == PPF_ACT_CMD)
		|=> $stable(st_q.cmd))
		else $error("command changed without load");
	chk_erase_keeps: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) (o_op_start && o_op_cmd == PPF_CMD_ERASE
		&& !$past(i_serial_wr)) |-> $stable(st_q.fuses))
		else $error("chip erase changed fuses");
	chk_lock_blocks: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) fuse_locked |=> $stable(st_q.fuses))
		else $error("fuses changed while locked");
	chk_defer_fuse: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) (i_prog_mode && $past(i_prog_mode))
		|=> $stable(o_active_fuses))
		else $error("active fuses changed in programming mode");
	chk_ext_unused: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) (st_q.fuses.ext & PPF_EXT_UNUSED_MASK)
		== PPF_EXT_UNUSED_MASK)
		else $error("unused extended fuse bits not one");
	chk_sprog_serial: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) (i_serial_wr && !(st_q.state == PPF_IDLE
		&& wr_fall)) |=> $stable(st_q.fuses.high[PPF_BIT_SPROG]))
		else $error("serial path changed serial enable");
	cov_erase: cover property (@(posedge i_clock)
		o_op_start && o_op_cmd == PPF_CMD_ERASE);
	cov_fuse_write: cover property (@(posedge i_clock)
		o_op_start && o_op_cmd == PPF_CMD_WR_FUSE);
	cov_page_latch: cover property (@(posedge i_clock) o_page_latch);
	cov_read: cover property (@(posedge i_clock) o_data_oe);
	chk_oe_follows: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		(i_prog_mode && !pins.oe_n) |=> o_data_oe)
		else $error("data not driven while oe low");
	chk_page_data: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		(pg_rise && i_prog_mode) |=> o_page_latch
		&& o_flash_wdata == {$past(st_q.data_hi), $past(st_q.data_lo)})
		else $error("page load did not latch data bytes");
	chk_ready_idle: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		st_q.state == PPF_IDLE |-> o_ready_busy_out)
		else $error("ready low while idle");
	chk_busy_release: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		(st_q.state == PPF_BUSY && st_q.busy_cnt == BUSY_LAST)
		|=> o_ready_busy_out)
		else $error("ready not back after busy time");
	chk_no_start_busy: assert property (@(posedge i_clock)
		disable iff (!i_rst_n)
		st_q.state == PPF_BUSY |=> !o_op_start)
		else $error("operation started while busy");
	cov_serial_write: cover property (@(posedge i_clock)
		i_serial_wr && !fuse_locked);
endmodule : ppf_prog_port
